//--- casid_pkg.sv
// How it works
// RULE1: Instructions span one to four bytes.
// RULE2: Escape byte opens a second op-code page.
// RULE3: Second escape page holds 16-bit/stack ops only; the code rejects every op on this page as illegal.
// RULE4: Low three op-code bits select addressing mode.
// RULE5: Register and index modes fetch no operand.
// RULE6: Single-operand modes take one byte unchanged.
// RULE7: Wide operands arrive low byte then high.
// RULE8: Absolute-immediate form: address first, data second.
// RULE9: Implied-register ops carry no operand field.
// RULE10: Bank and page registers only in large models.
// RULE11: Base add codes add into accumulator A.
// RULE12: Escaped add codes index or memory destination.
// RULE13: Add-with-carry repeats add, plus carry in.
// RULE14: Subtract repeats add patterns, subtracting source.
// RULE15: Arithmetic updates Z C V N, keeps interrupts.
// RULE16: Displacement byte sign-extended onto index.
// RULE17: Base page register forms high address byte.
// RULE18: L register acts as signed index offset.
// RULE19: Present decode only after all bytes, stall otherwise.
// RULE20: Result written to A or pointer memory.
package casid_pkg;
   localparam logic [7:0] ESC_CE = 8'hCE;
   localparam logic [7:0] ESC_CF = 8'hCF;
   localparam logic [7:0] LAST_OP = 8'h17;
   localparam logic [2:0] MAX_LEN = 3'h4;
   localparam logic [1:0] PG_BASE = 2'h0;
   localparam logic [1:0] PG_CE = 2'h1;
   localparam logic [1:0] PG_CF = 2'h2;
   localparam logic [3:0] CYC_REG = 4'h2;
   localparam logic [3:0] CYC_PAGE = 4'h3;
   localparam logic [3:0] CYC_ABS = 4'h4;
   localparam logic [3:0] CYC_ESC = 4'h4;
   localparam logic [3:0] CYC_ESC_MEM = 4'h5;
   localparam logic [7:0] OFS_FETCH = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_DECODE = 8'h0C;
   localparam logic [7:0] OFS_OPERAND = 8'h10;
   localparam logic [7:0] OFS_EADDR = 8'h14;
   localparam logic [7:0] OFS_AB = 8'h18;
   localparam logic [7:0] OFS_HL = 8'h1C;
   localparam logic [7:0] OFS_IX = 8'h20;
   localparam logic [7:0] OFS_IY = 8'h24;
   localparam logic [7:0] OFS_BRSC = 8'h28;
   localparam logic [7:0] OFS_MSRC = 8'h2C;
   localparam logic [7:0] OFS_MDST = 8'h30;
   localparam logic [7:0] OFS_EP = 8'h34;
   localparam int FLAG_D = 4;
   localparam int FLAG_U = 5;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ESC = 5'b00010,
      ST_OPND1 = 5'b00100,
      ST_OPND2 = 5'b01000,
      ST_EXEC = 5'b10000
   } casid_state_e;

   // Operand bytes that follow the op-code
   function automatic logic [1:0] casid_opnd_f(input logic [1:0] page, input logic [7:0] op);
      logic [1:0] n;
      n = 2'h0;
      if (page == PG_BASE)
      begin
         case (op[2:0])
            3'h2, 3'h4: n = 2'h1;
            3'h5: n = 2'h2;
            default: n = 2'h0;
         endcase
      end
      else if (page == PG_CE)
      begin
         case (op[2:0])
            3'h0, 3'h1, 3'h5: n = 2'h1;
            default: n = 2'h0;
         endcase
      end
      return n;
   endfunction : casid_opnd_f

   // Instruction cycles per group member
   function automatic logic [3:0] casid_cyc_f(input logic [1:0] page, input logic [7:0] op);
      logic [3:0] c;
      c = CYC_REG;
      if (page == PG_BASE)
      begin
         c = (op[2:0] == 3'h4) ? CYC_PAGE : (op[2:0] == 3'h5) ? CYC_ABS : CYC_REG;
      end
      else
      begin
         c = (op[2:0] >= 3'h5) ? CYC_ESC_MEM : CYC_ESC;
      end
      return c;
   endfunction : casid_cyc_f
endpackage : casid_pkg

//--- casid_alu.sv
`timescale 1ns/1ps
`default_nettype none
module casid_alu
   import casid_pkg::*;
(
   // Operands
   input wire logic [7:0] dst,
   input wire logic [7:0] src,
   // Control
   input wire logic carry_in,
   input wire logic use_carry,
   input wire logic subtract,
   input wire logic decimal,
   input wire logic unpack,
   // Results, flags as N V C Z
   output logic [7:0] result,
   output logic [3:0] flags
);
   logic cin;
   logic [7:0] a;
   logic [7:0] b;
   logic [8:0] bin;
   logic [4:0] lo;
   logic [4:0] hi;
   logic lo_c;
   logic hi_c;
   logic c;
   logic v;

   always_comb
   begin
      cin = carry_in & use_carry; // see RULE13
      a = unpack ? {4'h0, dst[3:0]} : dst;
      b = unpack ? {4'h0, src[3:0]} : src;
      bin = subtract ? {1'b0, a} - {1'b0, b} - {8'h00, cin} : {1'b0, a} + {1'b0, b} + {8'h00, cin}; // see RULE14
      lo = subtract ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin} : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      lo_c = (subtract || !decimal) ? lo[4] : (lo > 5'h09);
      lo = (decimal && lo_c) ? (subtract ? lo - 5'h06 : lo + 5'h06) : lo;
      hi = subtract ? {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo_c} : {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo_c};
      hi_c = subtract ? hi[4] : (hi > 5'h09);
      hi = hi_c ? (subtract ? hi - 5'h06 : hi + 5'h06) : hi;
      // Decimal and unpack modes change digit handling
      if (unpack)
      begin
         result = {4'h0, lo[3:0]};
         c = lo_c;
      end
      else if (decimal)
      begin
         result = {hi[3:0], lo[3:0]};
         c = hi_c;
      end
      else
      begin
         result = bin[7:0];
         c = bin[8];
      end
      v = subtract ? (a[7] != b[7]) && (result[7] != a[7]) : (a[7] == b[7]) && (result[7] != a[7]);
      flags = {result[7], v, c, result == 8'h00}; // see RULE15
   end
endmodule : casid_alu
`default_nettype wire

//--- casid_top.sv
`timescale 1ns/1ps
`default_nettype none
module casid_top
   import casid_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CLKS_PER_CYCLE = 1,
   parameter bit LARGE_MODEL = 1'b1
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // Write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // Read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   casid_state_e state_q;
   logic awready_q, aw_full_q, wready_q, w_full_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [7:0] a_q, b_q, h_q, l_q, br_q, sc_q, msrc_q, mdst_q, ep_q, op_q, cnt_q;
   logic [15:0] ix_q, iy_q, opnd_q;
   logic [1:0] page_q;
   logic [2:0] len_q;
   logic illegal_q;
   logic wr_go, wr_err, fetch_take, st_exec, wb, dst_mem, esc;
   logic [7:0] fbyte, src_val, dst_val, alu_res, rd_addr;
   logic [3:0] alu_flags;
   logic [2:0] mode;
   logic [1:0] group;
   logic [15:0] eaddr;

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   assign st_exec = state_q == ST_EXEC;
   assign wr_go = aw_full_q && w_full_q && !bvalid_q;
   assign fbyte = wdata_q[7:0];
   assign wr_err = (waddr_q > OFS_EP) || (waddr_q[1:0] != 2'h0) || (waddr_q == 8'h00)
      || (st_exec && (waddr_q == OFS_FETCH || waddr_q >= OFS_AB))
      || (!LARGE_MODEL && waddr_q == OFS_EP);
   assign fetch_take = wr_go && !wr_err && waddr_q == OFS_FETCH && wstrb_q[0]; // see RULE19
   assign wb = st_exec && cnt_q == 8'h01;
   assign rd_addr = 8'(araddr);

   // Write address channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b0;
         waddr_q <= RST_BYTE;
      end
      else if (awvalid && awready_q)
      begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b1;
         waddr_q <= 8'(awaddr);
      end
      else if (wr_go)
      begin
         awready_q <= 1'b1;
         aw_full_q <= 1'b0;
      end
      else
      begin
         awready_q <= !aw_full_q;
      end
   end

   // Write data channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_q <= 1'b0;
         w_full_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end
      else if (wvalid && wready_q)
      begin
         wready_q <= 1'b0;
         w_full_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end
      else if (wr_go)
      begin
         wready_q <= 1'b1;
         w_full_q <= 1'b0;
      end
      else
      begin
         wready_q <= !w_full_q;
      end
   end

   // Write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY; // see RULE19
      end
      else if (bready)
      begin
         bvalid_q <= 1'b0;
      end
   end

   // Current instruction view
   always_comb
   begin
      mode = op_q[2:0]; // see RULE4
      group = op_q[4:3];
      esc = page_q == PG_CE;
      dst_mem = esc && mode >= 3'h4;
      src_val = msrc_q;
      eaddr = RST_WORD;
      if (!esc)
      begin
         case (mode)
            3'h0: src_val = a_q; // see RULE5
            3'h1: src_val = b_q;
            3'h2: src_val = opnd_q[7:0]; // see RULE6
            default: src_val = msrc_q;
         endcase
         case (mode)
            3'h3: eaddr = {h_q, l_q};
            3'h4: eaddr = {br_q, opnd_q[7:0]}; // see RULE17
            3'h5: eaddr = opnd_q; // see RULE7
            3'h6: eaddr = ix_q;
            3'h7: eaddr = iy_q;
            default: eaddr = RST_WORD;
         endcase
      end
      else
      begin
         case (mode)
            3'h4: src_val = a_q;
            3'h5: src_val = opnd_q[7:0];
            default: src_val = msrc_q;
         endcase
         case (mode)
            3'h0: eaddr = ix_q + {{8{opnd_q[7]}}, opnd_q[7:0]}; // see RULE16
            3'h1: eaddr = iy_q + {{8{opnd_q[7]}}, opnd_q[7:0]}; // see RULE16
            3'h2: eaddr = ix_q + {{8{l_q[7]}}, l_q}; // see RULE18
            3'h3: eaddr = iy_q + {{8{l_q[7]}}, l_q}; // see RULE18
            3'h6: eaddr = ix_q;
            3'h7: eaddr = iy_q;
            default: eaddr = {h_q, l_q};
         endcase
      end
      dst_val = dst_mem ? mdst_q : a_q; // see RULE12
   end

   casid_alu u_alu (
      .dst(dst_val),
      .src(src_val),
      .carry_in(sc_q[1]),
      .use_carry(group == 2'h1),
      .subtract(group == 2'h2),
      .decimal(sc_q[FLAG_D]),
      .unpack(sc_q[FLAG_U]),
      .result(alu_res),
      .flags(alu_flags)
   );

   // Fetch and decode sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ST_IDLE;
         page_q <= PG_BASE;
         op_q <= RST_BYTE;
         opnd_q <= RST_WORD;
         len_q <= 3'h0;
         illegal_q <= 1'b0;
         cnt_q <= RST_BYTE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (fetch_take)
               begin
                  len_q <= 3'h1; // see RULE1
                  illegal_q <= 1'b0;
                  opnd_q <= RST_WORD;
                  if (fbyte == ESC_CE || fbyte == ESC_CF)
                  begin
                     page_q <= (fbyte == ESC_CE) ? PG_CE : PG_CF; // see RULE2
                     state_q <= ST_ESC;
                  end
                  else
                  begin
                     page_q <= PG_BASE;
                     op_q <= fbyte;
                     illegal_q <= fbyte > LAST_OP;
                     cnt_q <= 8'(int'(casid_cyc_f(PG_BASE, fbyte)) * CLKS_PER_CYCLE); // see RULE11
                     if (fbyte > LAST_OP)
                        state_q <= ST_IDLE;
                     else if (casid_opnd_f(PG_BASE, fbyte) == 2'h0)
                        state_q <= ST_EXEC; // see RULE5
                     else
                        state_q <= ST_OPND1;
                  end
               end
            end
            ST_ESC:
            begin
               if (fetch_take)
               begin
                  len_q <= len_q + 3'h1;
                  op_q <= fbyte;
                  cnt_q <= 8'(int'(casid_cyc_f(page_q, fbyte)) * CLKS_PER_CYCLE); // see RULE12
                  // Only the CE page group is executed here
                  if (page_q == PG_CF || fbyte > LAST_OP)
                  begin
                     illegal_q <= 1'b1; // see RULE3
                     state_q <= ST_IDLE;
                  end
                  else if (casid_opnd_f(page_q, fbyte) == 2'h0)
                     state_q <= ST_EXEC; // see RULE9
                  else
                     state_q <= ST_OPND1;
               end
            end
            ST_OPND1:
            begin
               if (fetch_take)
               begin
                  len_q <= len_q + 3'h1;
                  opnd_q[7:0] <= fbyte; // see RULE7
                  state_q <= (casid_opnd_f(page_q, op_q) == 2'h2) ? ST_OPND2 : ST_EXEC; // see RULE6
               end
            end
            ST_OPND2:
            begin
               if (fetch_take)
               begin
                  len_q <= len_q + 3'h1;
                  opnd_q[15:8] <= fbyte; // see RULE8
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC:
            begin
               cnt_q <= cnt_q - 8'h01;
               if (wb)
                  state_q <= ST_IDLE; // see RULE19
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Core registers, software writes and result write-back
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         a_q <= RST_BYTE;
         b_q <= RST_BYTE;
         h_q <= RST_BYTE;
         l_q <= RST_BYTE;
         ix_q <= RST_WORD;
         iy_q <= RST_WORD;
         br_q <= RST_BYTE;
         sc_q <= RST_BYTE;
         msrc_q <= RST_BYTE;
         mdst_q <= RST_BYTE;
         ep_q <= RST_BYTE;
      end
      else if (wb)
      begin
         if (dst_mem)
            mdst_q <= alu_res; // see RULE20
         else
            a_q <= alu_res; // see RULE11
         sc_q <= {sc_q[7:4], alu_flags}; // see RULE15
      end
      else if (wr_go && !wr_err)
      begin
         case (waddr_q)
            OFS_AB:
            begin
               if (wstrb_q[0]) a_q <= wdata_q[7:0];
               if (wstrb_q[1]) b_q <= wdata_q[15:8];
            end
            OFS_HL:
            begin
               if (wstrb_q[0]) l_q <= wdata_q[7:0];
               if (wstrb_q[1]) h_q <= wdata_q[15:8];
            end
            OFS_IX:
            begin
               if (wstrb_q[0]) ix_q[7:0] <= wdata_q[7:0];
               if (wstrb_q[1]) ix_q[15:8] <= wdata_q[15:8];
            end
            OFS_IY:
            begin
               if (wstrb_q[0]) iy_q[7:0] <= wdata_q[7:0];
               if (wstrb_q[1]) iy_q[15:8] <= wdata_q[15:8];
            end
            OFS_BRSC:
            begin
               if (wstrb_q[0]) br_q <= wdata_q[7:0];
               if (wstrb_q[1]) sc_q <= wdata_q[15:8];
            end
            OFS_MSRC: if (wstrb_q[0]) msrc_q <= wdata_q[7:0];
            OFS_MDST: if (wstrb_q[0]) mdst_q <= wdata_q[7:0];
            OFS_EP: if (wstrb_q[0]) ep_q <= wdata_q[7:0]; // see RULE10
            default: ep_q <= ep_q;
         endcase
      end
   end

   // Read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end
      else if (arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         case (rd_addr)
            OFS_FETCH: rdata_q <= 32'h00000000;
            OFS_STATUS: rdata_q <= {25'h0, len_q, LARGE_MODEL, illegal_q,
               !st_exec && state_q != ST_IDLE, st_exec};
            OFS_DECODE: rdata_q <= {8'h00, op_q, casid_cyc_f(page_q, op_q), 2'h0, casid_opnd_f(page_q, op_q),
               1'b0, page_q, group, mode};
            OFS_OPERAND: rdata_q <= {16'h0000, opnd_q};
            OFS_EADDR: rdata_q <= {16'h0000, eaddr};
            OFS_AB: rdata_q <= {16'h0000, b_q, a_q};
            OFS_HL: rdata_q <= {16'h0000, h_q, l_q};
            OFS_IX: rdata_q <= {16'h0000, ix_q};
            OFS_IY: rdata_q <= {16'h0000, iy_q};
            OFS_BRSC: rdata_q <= {16'h0000, sc_q, br_q};
            OFS_MSRC: rdata_q <= {24'h000000, msrc_q};
            OFS_MDST: rdata_q <= {24'h000000, mdst_q};
            OFS_EP: rdata_q <= LARGE_MODEL ? {24'h000000, ep_q} : 32'h00000000; // see RULE10
            default:
            begin
               rdata_q <= 32'h00000000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && rready)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
      else
      begin
         arready_q <= !rvalid_q;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_LEN_MAX: assert property (len_q <= MAX_LEN) else $error("instruction longer than four bytes"); // see RULE1
   AST_ESC_OPEN: assert property (state_q == ST_IDLE && fetch_take && fbyte == ESC_CE // see RULE2
      |=> state_q == ST_ESC && page_q == PG_CE) else $error("escape byte did not open extended page");
   AST_CF_REJECT: assert property (state_q == ST_ESC && fetch_take && page_q == PG_CF // see RULE3
      |=> state_q == ST_IDLE && illegal_q) else $error("second escape page executed");
   AST_NO_OPERAND: assert property (state_q == ST_IDLE && fetch_take && fbyte <= LAST_OP // see RULE5
      && fbyte[2:0] inside {3'h0, 3'h1, 3'h3, 3'h6, 3'h7}
      |=> st_exec && mode == $past(fbyte[2:0])) else $error("operand fetched for register mode");
   AST_ONE_OPERAND: assert property (state_q == ST_OPND1 && fetch_take // see RULE6
      && casid_opnd_f(page_q, op_q) == 2'h1 |=> st_exec && opnd_q[7:0] == $past(fbyte))
      else $error("single operand not taken as is");
   AST_LOW_HIGH: assert property (state_q == ST_OPND2 && fetch_take // see RULE7
      |=> opnd_q == {$past(fbyte), $past(opnd_q[7:0])}) else $error("wide operand byte order wrong");
   AST_CNT_LOAD: assert property (st_exec && !$past(st_exec) // see RULE11
      |-> cnt_q == 8'(int'(casid_cyc_f(page_q, op_q)) * CLKS_PER_CYCLE)) else $error("cycle count mismatch");
   AST_ESC_MEM_CYC: assert property (st_exec && !$past(st_exec) && esc && mode >= 3'h5 // see RULE12
      |-> cnt_q == 8'(int'(CYC_ESC_MEM) * CLKS_PER_CYCLE)) else $error("escaped memory add not five cycles");
   AST_INT_KEEP: assert property (wb |=> sc_q[7:6] == $past(sc_q[7:6]) && sc_q[3:0] == $past(alu_flags)) // see RULE15
      else $error("flag update wrong");
   AST_WB_A: assert property (wb && !dst_mem |=> a_q == $past(alu_res) && state_q == ST_IDLE) // see RULE20
      else $error("accumulator not written");
   AST_STALL: assert property (wr_go && st_exec && waddr_q == OFS_FETCH // see RULE19
      |=> bvalid_q && bresp_q == RESP_SLVERR && $stable(len_q)) else $error("fetch accepted while executing");
   AST_IDX_L: assert property (esc && mode == 3'h2 |-> eaddr == ix_q + {{8{l_q[7]}}, l_q}) // see RULE18
      else $error("index plus L address wrong");

   COV_ESC_ADD: cover property (st_exec && esc && mode == 3'h5 ##[1:20] wb);
   COV_ABS16: cover property (state_q == ST_OPND2 && fetch_take ##1 st_exec);
   COV_REFUSED: cover property (wr_go && st_exec && waddr_q == OFS_FETCH);
endmodule : casid_top
`default_nettype wire

//--- casid_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module casid_mem_model
(
   // Lookup
   input wire logic [15:0] addr,
   output logic [7:0] data
);
   // Flat data space, no bank or page registers as in small models
   assign data = addr[7:0] ^ addr[15:8] ^ 8'h5A;
endmodule : casid_mem_model
`default_nettype wire

//--- casid_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module casid_top_tb
   import casid_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, rnd, a, b, sc, op, m;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rp, g;
   logic [11:0] e;
   logic [15:0] ma;
   int error_cnt, compares, cyc;

   casid_top #(.CLKS_PER_CYCLE(4)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   casid_mem_model i_mem (.addr(ma), .data(m));

   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // Expected N V C Z and result
   function automatic logic [11:0] alu_f(input logic [1:0] gr, input logic [7:0] x, input logic [7:0] y,
      input logic c);
      logic [8:0] s;
      logic v;
      s = (gr == 2'h2) ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y} + {8'h00, c & (gr == 2'h1)};
      v = (gr == 2'h2) ? (x[7] != y[7]) && (s[7] != x[7]) : (x[7] == y[7]) && (s[7] != x[7]);
      return {s[7], v, s[8], s[7:0] == 8'h00, s[7:0]};
   endfunction : alu_f

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready && arvalid) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   // Send n bytes, lowest first, then wait for the end of execution
   task automatic ins(input int n, input logic [23:0] by);
      for (int k = 0; k < n; k++)
      begin
         wr(OFS_FETCH, {24'h0, by[8*k +: 8]}, rp);
         chk(32'(rp), 32'(RESP_OKAY));
      end
      rv = 32'h1;
      for (int k = 0; k < 60 && rv[0] !== 1'b0; k++) rd(OFS_STATUS, rv, rp);
   endtask : ins

   task automatic src(input logic [15:0] ad);
      ma = ad;
      #1;
      wr(OFS_MSRC, {24'h0, m}, rp);
   endtask : src

   task automatic complete_run;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         complete_run;
      end
   end

   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      ma = 16'h0000;
      rnd = 8'h29;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(OFS_STATUS, rv, rp);
      chk(rv, 32'h8);
      rd(8'h38, rv, rp);
      chk(32'(rp), 32'(RESP_SLVERR));
      wr(OFS_EP, 32'h3, rp);
      chk(32'(rp), 32'(RESP_OKAY));
      for (int i = 0; i < 12; i++)
      begin
         a = rnd;
         b = lfsr(a);
         sc = lfsr(b) & 8'hCF;
         rnd = lfsr(lfsr(b));
         g = 2'(i % 3);
         op = {3'h0, g, i[0] ? 3'h1 : 3'h2};
         wr(OFS_AB, {16'h0, b, a}, rp);
         wr(OFS_BRSC, {16'h0, sc, 8'h00}, rp);
         ins(i[0] ? 1 : 2, {8'h00, b, op});
         e = alu_f(g, a, b, sc[1]);
         rd(OFS_AB, rv, rp);
         chk(rv, {16'h0, b, e[7:0]});
         rd(OFS_BRSC, rv, rp);
         chk(rv, {16'h0, sc[7:4], e[11:8], 8'h00});
         rd(OFS_DECODE, rv, rp);
         chk(rv, {8'h00, op, CYC_REG, 3'h0, ~i[0], 3'h0, op[4:0]});
      end
      wr(OFS_BRSC, 32'h00A5, rp);
      wr(OFS_AB, 32'h0010, rp);
      src(16'hA533);
      ins(2, 24'h003304);
      rd(OFS_EADDR, rv, rp);
      chk(rv, 32'hA533);
      rd(OFS_AB, rv, rp);
      chk(rv, {24'h0, 8'h10 + m});
      rd(OFS_DECODE, rv, rp);
      chk(rv, {8'h00, 8'h04, CYC_PAGE, 4'h1, 8'h04});
      src(16'hC721);
      ins(3, 24'hC72115);
      rd(OFS_OPERAND, rv, rp);
      chk(rv, 32'hC721);
      rd(OFS_DECODE, rv, rp);
      chk(rv, {8'h00, 8'h15, CYC_ABS, 4'h2, 8'h15});
      wr(OFS_IX, 32'h1200, rp);
      ins(3, 24'hF000CE);
      rd(OFS_EADDR, rv, rp);
      chk(rv, 32'h11F0);
      rd(OFS_DECODE, rv, rp);
      chk(rv, {8'h00, 8'h00, CYC_ESC, 4'h1, 8'h20});
      wr(OFS_HL, 32'h4085, rp);
      ins(2, 24'h0002CE);
      rd(OFS_EADDR, rv, rp);
      chk(rv, 32'h1185);
      rd(OFS_DECODE, rv, rp);
      chk(rv, {8'h00, 8'h02, CYC_ESC, 4'h0, 8'h22});
      wr(OFS_MDST, 32'h7F, rp);
      wr(OFS_BRSC, 32'h0200, rp);
      ins(3, 24'h010DCE);
      rd(OFS_MDST, rv, rp);
      chk(rv, 32'h81);
      rd(OFS_BRSC, rv, rp);
      chk(rv, 32'h0C00);
      rd(OFS_DECODE, rv, rp);
      chk(rv, {8'h00, 8'h0D, CYC_ESC_MEM, 4'h1, 8'h2D});
      wr(OFS_BRSC, 32'h1000, rp);
      wr(OFS_AB, 32'h2819, rp);
      ins(1, 24'h000001);
      rd(OFS_AB, rv, rp);
      chk(rv, 32'h2847);
      ins(1, 24'h000018);
      rd(OFS_STATUS, rv, rp);
      chk(rv & 32'h7, 32'h4);
      ins(2, 24'h0000CF);
      rd(OFS_STATUS, rv, rp);
      chk(rv, 32'h2C);
      wr(OFS_FETCH, 32'h0, rp);
      wr(OFS_FETCH, 32'h0, rp);
      chk(32'(rp), 32'(RESP_SLVERR));
      complete_run;
   end
endmodule : casid_top_tb
`default_nettype wire
